// ---- hdl/network_node_address_select.v ----
`timescale 1ns/10ps
`include "node_addr_regs.vh"
module network_node_address_select #(
  parameter SETTLE_CYCLES = `SETTLE_CYC,
  parameter CAN_VARIANT = 1
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [3:0] switch_left,
  input wire [3:0] switch_right,
  input wire [7:0] stored_addr,
  input wire [2:0] stored_rate,
  input wire stored_valid,
  input wire tx_active,
  output reg [7:0] node_addr_q,
  output reg [2:0] bit_rate_q,
  output reg addr_from_store_q,
  output reg rate_from_store_q,
  output reg config_valid_q,
  output reg config_error_q,
  output reg driver_oe_n_q
);
  wire [7:0] sw_clean;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [31:0] cnt_q;
  reg [7:0] addr_d;
  reg [2:0] rate_d;
  reg afs_d;
  reg rfs_d;
  reg err_d;
  reg addr_err_d;
  reg rate_err_d;
  wire in_wait;
  wire in_load;
  wire in_run;
  wire settle_done;

  // state codes; the header keeps the same values for the checker side
  localparam [1:0] ST_WAIT = `ST_WAIT;
  localparam [1:0] ST_LOAD = `ST_LOAD;
  localparam [1:0] ST_RUN = `ST_RUN;
  wire [7:0] sw_val;

  // switches are pins, so they cross into ref_clk first
  switch_sync #(
    .WIDTH(8)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .raw_in({switch_right, switch_left}),
    .clean_out(sw_clean)
  );

  assign sw_val = sw_clean;

  // address decode: soft cases, direct and offset cases
  // 8-bit address spans 1..255 so stored values above 127 fit
  always @* begin
    addr_d = sw_val;
    afs_d = 1'b0;
    addr_err_d = 1'b0;
    if (sw_val == `SW_SOFT_LO || sw_val == `SW_SOFT_HI) begin
      afs_d = 1'b1;
      addr_d = stored_addr;
      // zero is no legal node; fall back and flag it
      if (!stored_valid || stored_addr < `ADDR_MIN) begin
        addr_d = `ADDR_DEFAULT;
        addr_err_d = 1'b1;
      end
    end else if (sw_val > `SW_HW_OFFSET) begin
      addr_d = sw_val - `SW_HW_OFFSET;
    end else begin
      addr_d = sw_val;
    end
  end

  // rate decode; the RS485 build has no rate to pick
  always @* begin
    rate_d = `RATE_1M;
    rfs_d = 1'b0;
    rate_err_d = 1'b0;
    if (CAN_VARIANT != 0) begin
      if (sw_val[7] == 1'b0) begin
        rate_d = `RATE_1M;
      end else begin
        rfs_d = 1'b1;
        rate_d = stored_rate;
        // a bad code would leave both ends on different rates
        if (!stored_valid || stored_rate > `RATE_LAST) begin
          rate_d = `RATE_1M;
          rate_err_d = 1'b1;
        end
      end
    end else begin
      rate_d = `RATE_1M;
      rfs_d = 1'b0;
    end
  end

  // either fallback marks the whole capture as suspect
  always @* begin
    err_d = addr_err_d | rate_err_d;
  end

  assign in_wait = (state_q == ST_WAIT);
  assign in_load = (state_q == ST_LOAD);
  assign in_run = (state_q == ST_RUN);
  // let the sampler and store settle before the one capture
  assign settle_done = (cnt_q >= SETTLE_CYCLES - 1);

  // RUN is a sink: only a reset starts a new capture
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_WAIT: begin
        if (settle_done) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        state_d = ST_RUN;
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_WAIT;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= ST_WAIT;
    end else begin
      state_q <= state_d;
    end
  end

  // counter stops once the wait is over, so it cannot wrap in a long run
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
    end else if (in_wait) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      node_addr_q <= `ADDR_DEFAULT;
    end else if (in_load) begin
      node_addr_q <= addr_d;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      bit_rate_q <= `RATE_1M;
    end else if (in_load) begin
      bit_rate_q <= rate_d;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      addr_from_store_q <= 1'b0;
    end else if (in_load) begin
      addr_from_store_q <= afs_d;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      rate_from_store_q <= 1'b0;
    end else if (in_load) begin
      rate_from_store_q <= rfs_d;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      config_error_q <= 1'b0;
    end else if (in_load) begin
      config_error_q <= err_d;
    end
  end

  // valid rises with the captured values and then never falls
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      config_valid_q <= 1'b0;
    end else if (in_load) begin
      config_valid_q <= 1'b1;
    end
  end

  // drive the two-wire line only while sending, never before config;
  // a node with no address yet must not load the shared pair
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      driver_oe_n_q <= 1'b1;
    end else begin
      driver_oe_n_q <= ~(tx_active & in_run);
    end
  end
endmodule // network_node_address_select

// ---- hdl/node_addr_regs.vh ----
`ifndef NODE_ADDR_REGS_VH
`define NODE_ADDR_REGS_VH
`define SW_SOFT_LO 8'h00
`define SW_SOFT_HI 8'h80
`define SW_HW_OFFSET 8'h80
`define ADDR_MIN 8'h01
`define ADDR_MAX_HW 8'h7F
`define ADDR_DEFAULT 8'h01
`define MAX_NODES_RS485 254
`define MAX_NODES_CAN 127
`define RATE_1M 3'h0
`define RATE_500K 3'h1
`define RATE_250K 3'h2
`define RATE_125K 3'h3
`define RATE_50K 3'h4
`define RATE_20K 3'h5
`define RATE_LAST 3'h5
`define SETTLE_US 10
`define CLK_MHZ 200
`define SETTLE_CYC (`SETTLE_US * `CLK_MHZ)
`define ST_WAIT 2'h0
`define ST_LOAD 2'h1
`define ST_RUN 2'h2
`endif

// ---- hdl/switch_sync.v ----
`timescale 1ns/10ps
`include "node_addr_regs.vh"
// three-stage sampler per switch bit; a change counts once stages 2 and 3
// agree, so a bit caught mid-transition cannot reach the decoder
module switch_sync #(
  parameter WIDTH = 8
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [WIDTH-1:0] raw_in,
  output wire [WIDTH-1:0] clean_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg out_q;
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          out_q <= 1'b0;
        end else begin
          s1_q <= raw_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            out_q <= s3_q;
          end
        end
      end
      assign clean_out[i] = out_q;
    end
  endgenerate
endmodule // switch_sync

// ---- dv/node_addr_props.sv ----
`timescale 1ns/10ps
module node_addr_props #(
  parameter SETTLE_CYCLES = 8
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [3:0] switch_left,
  input wire [3:0] switch_right,
  input wire tx_active,
  input wire [7:0] node_addr_q,
  input wire [2:0] bit_rate_q,
  input wire addr_from_store_q,
  input wire rate_from_store_q,
  input wire config_valid_q,
  input wire config_error_q,
  input wire driver_oe_n_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  reg cv_prev_q;
  wire rv;
  always @(posedge ref_clk) begin
    cv_prev_q <= config_valid_q;
  end
  // capture strobe: first sampled cycle with the config valid
  assign rv = config_valid_q && !cv_prev_q;
  chk_load_time: assert property (
    $rose(rst_n) |-> !config_valid_q[*8] ##[2:3] config_valid_q) else $error("t");
  chk_valid_hold: assert property (
    config_valid_q |=> config_valid_q) else $error("v");
  chk_cfg_frozen: assert property (
    config_valid_q |=> $stable({node_addr_q, bit_rate_q})) else $error("f");
  chk_store_select: assert property (
    rv |-> addr_from_store_q == ({switch_right[2:0], switch_left} == 7'h00)
  ) else $error("s");
  chk_switch_addr: assert property (
    rv && !addr_from_store_q |-> node_addr_q == {1'b0, switch_right[2:0],
    switch_left}) else $error("a");
  chk_hw_range: assert property (
    rv && !addr_from_store_q |-> node_addr_q inside {[1:127]}) else $error("r");
  chk_fixed_rate: assert property (
    rv && !switch_right[3] |-> bit_rate_q == 3'h0 && !rate_from_store_q
  ) else $error("b");
  chk_error_flag: assert property (
    rv && !addr_from_store_q && !rate_from_store_q |-> !config_error_q
  ) else $error("e");
  chk_rate_code: assert property (
    config_valid_q |-> bit_rate_q <= 3'h5) else $error("c");
  chk_driver_dir: assert property (
    $past(config_valid_q, 2) |-> driver_oe_n_q == !$past(tx_active)
  ) else $error("d");
  cover property (rv && addr_from_store_q);
  cover property (rv && rate_from_store_q);
  cover property (!driver_oe_n_q);
endmodule // node_addr_props
bind network_node_address_select node_addr_props #(
  .SETTLE_CYCLES(SETTLE_CYCLES)) props_i (.*);

// ---- dv/nv_store_model.sv ----
`timescale 1ns/10ps
// stands in for the nonvolatile store the far side programs
module nv_store_model (
  input wire ref_clk,
  input wire [7:0] addr_in,
  input wire [2:0] rate_in,
  output reg [7:0] stored_addr,
  output reg [2:0] stored_rate,
  output reg stored_valid
);
  initial stored_valid = 1'b0;
  always @(posedge ref_clk) begin
    stored_addr <= addr_in;
    stored_rate <= rate_in;
    stored_valid <= 1'b1;
  end
endmodule // nv_store_model

// ---- dv/tb.sv ----
`timescale 1ns/10ps
module tb;
  reg ref_clk = 0, rst_n = 0, tx_active = 0;
  reg [7:0] sw = 0, sa = 8'hC8;
  reg [2:0] sr = 3'h3;
  wire [7:0] st_a, na;
  wire [2:0] st_r, br;
  wire st_v, cv, oe_n, afs, rfs, cerr;
  integer err_count = 0, num_checks = 0, i;
  always #2.5 ref_clk = ~ref_clk;
  nv_store_model nv_store_model_i (.ref_clk(ref_clk), .addr_in(sa),
    .rate_in(sr), .stored_addr(st_a), .stored_rate(st_r),
    .stored_valid(st_v));
  network_node_address_select #(.SETTLE_CYCLES(8))
    network_node_address_select_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .switch_left(sw[3:0]), .switch_right(sw[7:4]), .stored_addr(st_a),
    .stored_rate(st_r), .stored_valid(st_v), .tx_active(tx_active),
    .node_addr_q(na), .bit_rate_q(br), .addr_from_store_q(afs),
    .rate_from_store_q(rfs), .config_valid_q(cv), .config_error_q(cerr),
    .driver_oe_n_q(oe_n));
  task chk(input [13:0] g, input [13:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // restart with a new switch setting, then judge the capture
  task boot(input [7:0] s, input [7:0] ea, input [2:0] er,
    input [2:0] ef);
    begin
      sw = s;
      rst_n = 0;
      repeat (8) @(posedge ref_clk);
      #1 rst_n = 1;
      for (i = 0; i < 40 && cv !== 1'b1; i = i + 1) @(posedge ref_clk);
      #1 chk({na, br, afs, rfs, cerr}, {ea, er, ef});
    end
  endtask
  task t_switch;
    begin
      boot(8'h21, 8'h21, 3'h0, 3'h0);
      boot(8'h7F, 8'h7F, 3'h0, 3'h0);
      boot(8'hFF, 8'h7F, 3'h3, 3'h2);
      boot(8'h81, 8'h01, 3'h3, 3'h2);
    end
  endtask
  task t_store;
    begin
      boot(8'h80, 8'hC8, 3'h3, 3'h6);
      sa = 8'h00;
      sr = 3'h7;
      boot(8'h80, 8'h01, 3'h0, 3'h7);
      sa = 8'hFF;
      sr = 3'h5;
      boot(8'h00, 8'hFF, 3'h0, 3'h4);
      boot(8'h80, 8'hFF, 3'h5, 3'h6);
    end
  endtask
  // late switch moves must not leak into the running config
  task t_run;
    begin
      sw = 8'h05;
      tx_active = 1;
      repeat (20) @(posedge ref_clk);
      #1 chk({na, br, afs, rfs, cerr}, {8'hFF, 3'h5, 3'h6});
      chk({13'h0, oe_n}, 14'h0);
      tx_active = 0;
      repeat (2) @(posedge ref_clk);
      #1 chk({13'h0, oe_n}, 14'h1);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    #1;
    t_switch;
    t_store;
    t_run;
    end_of_test;
  end
  initial begin
    #5000;
    err_count = err_count + 1;
    end_of_test;
  end
endmodule // tb
